// File: rtl/sample_timing_sync_control.sv
// sample timing control: time base select, external trigger, external alignment
// assumes an AXI4-Lite master on aclk and a sample front end on aclk
// Operation
// - internal 512 kHz time base by default
// - external clock on master or bit pin
// - external clock divided by four-bit field
// - trigger only in sar modes, any clock
// - one sample per enabled trigger pulse
// - trigger source bit1, enable bit0
// - alignment only in sigma-delta modes
// - data-ready phase follows sync pulse
// - bit6 selects sync source pin
// - sync mode: none, direct, interpolated
// - mode 00 default, clock source bits1:0
// - mode 00 free sampling with data-ready
// - mode 01 realigns on every pulse
// - mode 10 needs no external clock
// - interpolation averages two last samples
// - divider 0011 divides by four
`timescale 1ns/1ps
`default_nettype none
module sample_timing_sync_control
#(
   parameter int unsigned ODR_DIV = sample_timing_pkg::DEFAULT_ODR_DIV
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite slave
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pins and sample front end
   input  wire logic        master_clock_pin,
   input  wire logic        bit_clock_pin,
   input  wire logic        frame_sync_pin,
   input  wire logic        interrupt_pin_one,
   input  wire logic [15:0] sample_in,
   output logic [15:0]      sample_data,
   output logic             data_ready_signal,
   output logic             sample_tick
);
   if (ODR_DIV < 2 || ODR_DIV > 65535)
   begin
      $error("ODR_DIV out of range");
   end

   typedef enum logic [2:0] {
      s_idle = 3'b001,
      s_run  = 3'b010,
      s_calc = 3'b100
   } state_e;

   // register word index from a byte address
   function automatic logic [7:0] reg_index(input logic [9:0] addr);
      reg_index = addr[9:2];
   endfunction

   // signed mean of two samples
   function automatic logic [15:0] mean2(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] sum;
      sum   = {a[15], a} + {b[15], b};
      mean2 = sum[16:1];
   endfunction

   logic [7:0]  clock_control;
   logic [7:0]  sync_configuration;
   logic [7:0]  trigger_configuration;
   sample_timing_pkg::op_mode_e op_mode;
   tick_if      tb ();
   state_e      state;
   logic [9:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic [1:0]  pin_sync_fs;
   logic [1:0]  pin_sync_i1;
   logic        trig_prev;
   logic        align_prev;
   logic [15:0] decim_count;
   logic [15:0] hist_new;
   logic [15:0] hist_old;
   logic [7:0]  calc_count;
   logic        path_sd;
   logic        path_sar;
   logic [1:0]  sync_mode;
   logic        sync_on;
   logic        trig_on;
   logic        trig_level;
   logic        align_level;
   logic        trig_edge;
   logic        align_edge;
   logic        odr_wrap;
   logic        do_write;
   logic [7:0]  wr_index;
   logic [7:0]  wr_byte;
   logic [31:0] next_rdata;
   logic        rd_hit;

   // time base divider
   time_base u_time_base
   (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .master_clock_pin (master_clock_pin),
      .bit_clock_pin    (bit_clock_pin),
      .tb               (tb.gen)
   );

   // source select drives the time base
   assign tb.source    = clock_control[sample_timing_pkg::CLOCK_SOURCE_SELECT_LSB +: 2];
   assign tb.divide    = clock_control[sample_timing_pkg::DIV_LSB +: 4];
   assign tb.half_rate = path_sar;

   // mode decode
   assign path_sd  = op_mode == sample_timing_pkg::high_perf_mode
                     || op_mode == sample_timing_pkg::reduced_bandwidth_mode
                     || op_mode == sample_timing_pkg::low_power_sd_mode;
   assign path_sar = op_mode == sample_timing_pkg::very_low_power_sar_mode
                     || op_mode == sample_timing_pkg::ultra_low_power_sar_mode
                     || op_mode == sample_timing_pkg::high_speed_sar_mode;
   assign sync_mode = sync_configuration[sample_timing_pkg::SYNC_MODE_LSB +: 2];
   // alignment only on the sigma-delta path
   assign sync_on  = path_sd && (sync_mode == sample_timing_pkg::SYNC_DIRECT
                     || sync_mode == sample_timing_pkg::SYNC_INTERP);
   // trigger only on the sar path
   assign trig_on  = path_sar && trigger_configuration[sample_timing_pkg::TRIG_EN_BIT];

   // two-stage synchronisers on the pulse pins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_sync_fs <= 2'h0;
         pin_sync_i1 <= 2'h0;
      end
      else
      begin
         pin_sync_fs <= {pin_sync_fs[0], frame_sync_pin};
         pin_sync_i1 <= {pin_sync_i1[0], interrupt_pin_one};
      end
   end

   assign trig_level  = trigger_configuration[sample_timing_pkg::TRIGGER_SOURCE_SELECT_BIT]
                        ? pin_sync_i1[1] : pin_sync_fs[1];
   assign align_level = sync_configuration[sample_timing_pkg::ALIGN_SRC_BIT]
                        ? pin_sync_i1[1] : pin_sync_fs[1];
   assign trig_edge   = trig_on && trig_level && !trig_prev;
   assign align_edge  = sync_on && align_level && !align_prev;
   assign odr_wrap    = tb.tick && decim_count == 16'(ODR_DIV - 1);

   // edge detect history
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_prev  <= 1'b0;
         align_prev <= 1'b0;
      end
      else
      begin
         trig_prev  <= trig_level;
         align_prev <= align_level;
      end
   end

   // run state: standby idles, interpolation waits out its calculation
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state <= s_idle;
      else
      begin
         unique case (state)
            s_idle:
               if (op_mode != sample_timing_pkg::standby_mode)
                  state <= s_run;
            s_run:
               if (op_mode == sample_timing_pkg::standby_mode)
                  state <= s_idle;
               // start the averaging delay on a sync pulse
               else if (align_edge && sync_mode == sample_timing_pkg::SYNC_INTERP)
                  state <= s_calc;
            s_calc:
               if (calc_count == 8'(sample_timing_pkg::CALC_CYCLES - 1))
                  state <= s_run;
            default:
               state <= s_idle;
         endcase
      end
   end

   // calculation delay counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn || state != s_calc)
         calc_count <= 8'h00;
      else
         calc_count <= calc_count + 8'h01;
   end

   // output data rate divider
   always_ff @(posedge aclk)
   begin
      if (!aresetn || state == s_idle)
         decim_count <= 16'h0000;
      // realign the decimation phase on every pulse
      else if (align_edge && sync_mode == sample_timing_pkg::SYNC_DIRECT)
         decim_count <= 16'h0000;
      else if (odr_wrap)
         decim_count <= 16'h0000;
      else if (tb.tick)
         decim_count <= decim_count + 16'h0001;
   end

   // interpolation history: two most recent internal samples
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hist_new <= 16'h0000;
         hist_old <= 16'h0000;
      end
      else if (state != s_idle && odr_wrap)
      begin
         hist_old <= hist_new;
         hist_new <= sample_in;
      end
   end

   // sample output and data-ready pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sample_data       <= 16'h0000;
         data_ready_signal <= 1'b0;
         sample_tick       <= 1'b0;
      end
      else
      begin
         data_ready_signal <= 1'b0;
         sample_tick       <= tb.tick;
         if (state == s_calc && calc_count == 8'(sample_timing_pkg::CALC_CYCLES - 1))
         begin
            // averaged output after the fixed delay
            sample_data       <= mean2(hist_new, hist_old);
            data_ready_signal <= 1'b1;
         end
         else if (state == s_run && trig_edge)
         begin
            sample_data       <= sample_in;
            data_ready_signal <= 1'b1;
         end
         else if (state == s_run && align_edge && sync_mode == sample_timing_pkg::SYNC_DIRECT)
         begin
            sample_data       <= sample_in;
            data_ready_signal <= 1'b1;
         end
         // free sampling when neither trigger nor interpolation
         // interpolation runs on internal samples only
         else if (state == s_run && odr_wrap && !trig_on
                  && !(sync_on && sync_mode == sample_timing_pkg::SYNC_INTERP))
         begin
            sample_data       <= sample_in;
            data_ready_signal <= 1'b1;
         end
      end
   end

   // write channel capture, address and data in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 10'h000;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_index = reg_index(aw_addr);
   assign wr_byte  = w_data[7:0];

   // write ready: one of each at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // registers reset to mode 00 and the internal source
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clock_control         <= sample_timing_pkg::REG_RESET;
         sync_configuration    <= sample_timing_pkg::REG_RESET;
         trigger_configuration <= sample_timing_pkg::REG_RESET;
         op_mode               <= sample_timing_pkg::standby_mode;
      end
      else if (do_write && w_strb[0])
      begin
         // clock setup accepted in standby only
         if (wr_index == sample_timing_pkg::CLOCK_CONTROL_IDX
             && op_mode == sample_timing_pkg::standby_mode)
            clock_control <= wr_byte;
         if (wr_index == sample_timing_pkg::SYNC_CONFIGURATION_IDX)
            sync_configuration <= wr_byte;
         if (wr_index == sample_timing_pkg::TRIGGER_CONFIGURATION_IDX)
            trigger_configuration <= wr_byte;
         if (wr_index == sample_timing_pkg::OPERATING_MODE_IDX
             && wr_byte[2:0] <= 3'(sample_timing_pkg::high_speed_sar_mode))
            op_mode <= sample_timing_pkg::op_mode_e'(wr_byte[2:0]);
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sample_timing_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         if (wr_index == sample_timing_pkg::CLOCK_CONTROL_IDX
             || wr_index == sample_timing_pkg::SYNC_CONFIGURATION_IDX
             || wr_index == sample_timing_pkg::TRIGGER_CONFIGURATION_IDX
             || wr_index == sample_timing_pkg::OPERATING_MODE_IDX)
            s_axi_bresp <= sample_timing_pkg::RESP_OKAY;
         else
            s_axi_bresp <= sample_timing_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read decode
   always_comb
   begin
      next_rdata = 32'h00000000;
      rd_hit     = 1'b1;
      unique case (reg_index(s_axi_araddr))
         sample_timing_pkg::CLOCK_CONTROL_IDX:         next_rdata[7:0] = clock_control;
         sample_timing_pkg::SYNC_CONFIGURATION_IDX:    next_rdata[7:0] = sync_configuration;
         sample_timing_pkg::TRIGGER_CONFIGURATION_IDX: next_rdata[7:0] = trigger_configuration;
         sample_timing_pkg::OPERATING_MODE_IDX:        next_rdata[2:0] = op_mode;
         sample_timing_pkg::SAMPLE_STATUS_IDX:
            next_rdata = {13'h0000, state, sample_data};
         default:                                      rd_hit = 1'b0;
      endcase
   end

   // read channel: answer one cycle after address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= sample_timing_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_hit ? sample_timing_pkg::RESP_OKAY
                                   : sample_timing_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: rtl/sample_timing_pkg.sv
// constants shared by the sample timing block and its time base
// assumes a single 40 MHz system clock and a 32-bit AXI4-Lite register bus
package sample_timing_pkg;
   // clock rate and derived time base
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned NOMINAL_HZ     = 512_000;
   localparam int unsigned OSC_DIV        = CLK_HZ / NOMINAL_HZ;
   localparam int unsigned CALC_DELAY_PS  = 2_150_000;
   localparam int unsigned CLK_PERIOD_PS  = 1_000_000_000 / (CLK_HZ / 1000);
   localparam int unsigned CALC_CYCLES    = (CALC_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned DEFAULT_ODR_DIV = 64;
   // register indices; byte address is four times the index
   localparam logic [7:0] CLOCK_CONTROL_IDX         = 8'h25;
   localparam logic [7:0] SYNC_CONFIGURATION_IDX    = 8'h35;
   localparam logic [7:0] TRIGGER_CONFIGURATION_IDX = 8'h49;
   localparam logic [7:0] OPERATING_MODE_IDX        = 8'h4a;
   localparam logic [7:0] SAMPLE_STATUS_IDX         = 8'h4b;
   localparam int unsigned ADDR_W = 10;
   localparam logic [7:0] REG_RESET = 8'h00;
   // field positions
   localparam int unsigned DIV_LSB      = 4;
   localparam int unsigned CLOCK_SOURCE_SELECT_LSB  = 0;
   localparam int unsigned ALIGN_SRC_BIT = 6;
   localparam int unsigned SYNC_MODE_LSB = 4;
   localparam int unsigned TRIGGER_SOURCE_SELECT_BIT = 1;
   localparam int unsigned TRIG_EN_BIT  = 0;
   // clock source codes
   localparam logic [1:0] SRC_INTERNAL = 2'h0;
   localparam logic [1:0] SRC_MASTER   = 2'h1;
   localparam logic [1:0] SRC_BIT      = 2'h2;
   // alignment modes
   localparam logic [1:0] SYNC_NONE   = 2'h0;
   localparam logic [1:0] SYNC_DIRECT = 2'h1;
   localparam logic [1:0] SYNC_INTERP = 2'h2;
   // operating modes
   typedef enum logic [2:0] {
      standby_mode, high_perf_mode, reduced_bandwidth_mode, low_power_sd_mode,
      very_low_power_sar_mode, ultra_low_power_sar_mode, high_speed_sar_mode
   } op_mode_e;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/tick_if.sv
// carries the system time base between the timing block and its divider
// assumes both ends run on aclk
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic       tick;
   logic [1:0] source;
   logic [3:0] divide;
   logic       half_rate;
   modport gen (output tick, input source, input divide, input half_rate);
   modport use_tick (input tick, output source, output divide, output half_rate);
endinterface
`default_nettype wire

// File: rtl/time_base.sv
// time base: internal nominal oscillator or divided external clock pin
// assumes clock pins are slow against aclk and arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module time_base
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic master_clock_pin,
   input  wire logic bit_clock_pin,
   tick_if.gen       tb
);
   logic [1:0] mclk_sync;
   logic [1:0] bclk_sync;
   logic       ext_prev;
   logic [7:0] osc_count;
   logic [3:0] ext_count;
   logic       raw_tick;
   logic       half_phase;
   logic       ext_level;
   logic       ext_edge;

   // two-stage synchronisers for the clock pins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mclk_sync <= 2'h0;
         bclk_sync <= 2'h0;
      end
      else
      begin
         mclk_sync <= {mclk_sync[0], master_clock_pin};
         bclk_sync <= {bclk_sync[0], bit_clock_pin};
      end
   end

   assign ext_level = (tb.source == sample_timing_pkg::SRC_MASTER) ? mclk_sync[1] : bclk_sync[1];
   assign ext_edge  = ext_level && !ext_prev;

   // external edges divided by field plus one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_prev  <= 1'b0;
         osc_count <= 8'h00;
         ext_count <= 4'h0;
         raw_tick  <= 1'b0;
      end
      else
      begin
         ext_prev <= ext_level;
         raw_tick <= 1'b0;
         if (tb.source == sample_timing_pkg::SRC_MASTER || tb.source == sample_timing_pkg::SRC_BIT)
         begin
            osc_count <= 8'h00;
            if (ext_edge)
            begin
               if (ext_count >= tb.divide)
               begin
                  ext_count <= 4'h0;
                  raw_tick  <= 1'b1;
               end
               else
                  ext_count <= ext_count + 4'h1;
            end
         end
         else if (osc_count == 8'(sample_timing_pkg::OSC_DIV - 1))
         begin
            osc_count <= 8'h00;
            raw_tick  <= 1'b1;
         end
         else
            osc_count <= osc_count + 8'h01;
      end
   end

   // internal oscillator runs at half rate for the sar path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         half_phase <= 1'b0;
         tb.tick    <= 1'b0;
      end
      else
      begin
         if (raw_tick)
            half_phase <= !half_phase;
         tb.tick <= raw_tick && (!tb.half_rate || half_phase
                    || tb.source != sample_timing_pkg::SRC_INTERNAL);
      end
   end
endmodule
`default_nettype wire

// File: sim/sample_timing_sync_control_chk.sv
// checker: bus answers and output pulse shapes of the timing block
// assumes a bind onto the top module, one aclk domain
`timescale 1ns/1ps
`default_nettype none
module sample_timing_sync_control_chk
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [15:0] sample_data,
   input wire logic        data_ready_signal,
   input wire logic        sample_tick
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write channels taken, read address taken
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_ans;
      s_wr |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   property p_rd_ans;
      s_rd |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_data_ready_signal;
      data_ready_signal |=> !data_ready_signal;
   endproperty
   a_data_ready_signal: assert property (p_data_ready_signal) else $error("data ready too long");
   property p_data;
      $changed(sample_data) |-> data_ready_signal;
   endproperty
   a_data: assert property (p_data) else $error("sample without ready");
   property p_tick;
      sample_tick |=> !sample_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick too long");
   property p_idle;
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !data_ready_signal;
   endproperty
   a_idle: assert property (p_idle) else $error("busy after reset");
endmodule
`default_nettype wire

// File: sim/host_pulse_model.sv
// host model: external clock and active-high trigger or alignment pulses
// assumes the bench sets run and calls pulse; pins idle low
`timescale 1ns/1ps
`default_nettype none
module host_pulse_model
(
   output logic master_clock_pin,
   output logic bit_clock_pin,
   output logic frame_sync_pin,
   output logic interrupt_pin_one
);
   logic run = 1'b0;
   // pins start low
   initial
   begin
      master_clock_pin = 1'b0;
      bit_clock_pin = 1'b0;
      frame_sync_pin = 1'b0;
      interrupt_pin_one = 1'b0;
   end
   // 2.048 MHz clock, low when stopped
   always
   begin
      #244;
      master_clock_pin = run & !master_clock_pin;
   end
   // wide high pulse, long low gap
   task automatic pulse(input logic s);
      if (s)
         interrupt_pin_one = 1'b1;
      else
         frame_sync_pin = 1'b1;
      #5800;
      interrupt_pin_one = 1'b0;
      frame_sync_pin = 1'b0;
      #60000;
   endtask
endmodule
`default_nettype wire

// File: sim/sample_timing_sync_control_tb.sv
// testbench: registers, alignment, trigger and free run of the timing block
// assumes the host model drives the pins; aclk at 40 MHz
`timescale 1ns/1ps
`default_nettype none
module sample_timing_sync_control_tb;
   localparam logic [7:0] cc_i = sample_timing_pkg::CLOCK_CONTROL_IDX;
   localparam logic [7:0] sc_i = sample_timing_pkg::SYNC_CONFIGURATION_IDX;
   localparam logic [7:0] tc_i = sample_timing_pkg::TRIGGER_CONFIGURATION_IDX;
   localparam logic [7:0] om_i = sample_timing_pkg::OPERATING_MODE_IDX;
   localparam logic [1:0] ok = sample_timing_pkg::RESP_OKAY;
   logic        aclk = 1'b0, aresetn = 1'b0, free = 1'b1;
   logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h12307c1c;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] sample_in = 16'h0, sample_data, exp_q[$];
   logic        data_ready_signal, sample_tick;
   logic        master_clock_pin, bit_clock_pin, frame_sync_pin, interrupt_pin_one;
   int          error_cnt = 0, checks_done = 0, n_data_ready_signal = 0, n0;
   sample_timing_sync_control #(.ODR_DIV(4)) DUT (.*, .s_axi_wstrb(4'hf));
   host_pulse_model host (.*);
   // 25 ns clock
   always #12.5 aclk = ~aclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // write both channels, release each when taken, then take the answer
   task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(a && w))
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         a = a | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
      end
      while (s_axi_bvalid !== 1'b1)
         @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1)
         @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1)
         @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, (r == ok) ? s_axi_rdata[29:0] : 30'h0}, {r, 22'h0, d});
   endtask
   // one selected pulse gives one sample, the other pin is ignored
   task automatic one(input logic s, input logic [7:0] i, input logic [7:0] v);
      free <= 1'b1;
      wr(i, v, ok);
      seed = lfsr(seed);
      sample_in <= seed[15:0];
      repeat (1000) @(posedge aclk);
      free <= 1'b0;
      exp_q.push_back(seed[15:0]);
      host.pulse(s);
      host.pulse(!s);
   endtask
   // every data ready is compared with the oldest note, or the live input in free run
   always @(posedge aclk)
      if (data_ready_signal === 1'b1)
      begin
         n_data_ready_signal++;
         if (free)
            chk({16'h0, sample_data}, {16'h0, sample_in});
         else if (exp_q.size() == 0)
            chk(32'h1, 32'h0);
         else
            chk({16'h0, sample_data}, {16'h0, exp_q.pop_front()});
      end
   // cuts a hang short
   initial
   begin
      #1500000;
      error_cnt++;
      finish_test;
   end
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(cc_i, 8'h00, ok);
      rd(sc_i, 8'h00, ok);
      rd(tc_i, 8'h00, ok);
      rd(8'h10, 8'h00, sample_timing_pkg::RESP_SLVERR);
      // master pin divided by four, set in standby
      wr(cc_i, 8'h31, ok);
      rd(cc_i, 8'h31, ok);
      host.run = 1'b1;
      wr(om_i, 8'h01, ok);
      wr(cc_i, 8'h00, ok);
      rd(cc_i, 8'h31, ok);
      one(1'b0, sc_i, 8'h20);
      one(1'b1, sc_i, 8'h60);
      // direct alignment answers within a few cycles of the pin
      free <= 1'b1;
      wr(sc_i, 8'h10, ok);
      n0 = n_data_ready_signal;
      fork
         host.pulse(1'b0);
      join_none
      repeat (8) @(posedge aclk);
      chk(32'(n_data_ready_signal > n0), 32'h1);
      wait fork;
      // internal base halved in sar mode, four ticks a sample
      wr(om_i, 8'h00, ok);
      wr(cc_i, 8'h00, ok);
      host.run = 1'b0;
      wr(sc_i, 8'h00, ok);
      wr(om_i, 8'h04, ok);
      n0 = n_data_ready_signal;
      repeat (2500) @(posedge aclk);
      chk(32'((n_data_ready_signal - n0) inside {[4:5]}), 32'h1);
      one(1'b0, tc_i, 8'h01);
      one(1'b1, tc_i, 8'h03);
      repeat (100) @(posedge aclk);
      chk(32'(exp_q.size()), 32'h0);
      finish_test;
   end
endmodule
bind sample_timing_sync_control sample_timing_sync_control_chk chk (.*);
`default_nettype wire
